// ### src/smem_defs.svh
// Purpose: constants for the serial memory target
// Assumes: included by its bare name
// Notes: field positions refer to the slave address byte
`ifndef SMEM_DEFS_SVH
`define SMEM_DEFS_SVH

`define SMEM_ADDR_W        9
`define SMEM_DATA_W        8
`define SMEM_DEPTH         512
`define SMEM_ADDR_RST      9'h000
`define SMEM_ADDR_TOP      9'h1FF
`define SMEM_BIT_LAST      4'h7
`define SMEM_BIT_ACK       4'h8
`define SMEM_BIT_FIRST     4'h0
`define SMEM_SA_TYPE_HI    7
`define SMEM_SA_TYPE_LO    4
`define SMEM_SA_SEL_HI     3
`define SMEM_SA_SEL_LO     2
`define SMEM_SA_PAGE       1
`define SMEM_SA_RW         0
// arbitrary type code, not tied to any real part
`define SMEM_TYPE_CODE_DEF 4'h6

`endif

// ### src/smem_pkg.sv
// Purpose: types shared by the serial memory target
// Assumes: nothing beyond standard SystemVerilog
// Notes: state codes are one-hot
package smem_pkg;

   typedef enum logic [4:0] {
      SMEM_ST_ADDR   = 5'h01,
      SMEM_ST_WORD   = 5'h02,
      SMEM_ST_WDATA  = 5'h04,
      SMEM_ST_RDATA  = 5'h08,
      SMEM_ST_IGNORE = 5'h10
   } smem_state_e;

   typedef struct packed {
      logic bus_idle;
      logic selected;
      logic reading;
   } smem_status_s;

   typedef logic [8:0] smem_addr_t;

endpackage

// ### src/smem_target.sv
// Purpose: two-wire target interface and 512 x 8 array of a serial memory
// Assumes: scl_in is the link clock of its own domain; sda is open drain
// Notes: start/stop found on sys_clk_in, protocol engine runs on scl_in
//
// Operation
// [RULE1] an acknowledge slot follows every eighth bit; sender releases, receiver pulls low
// [RULE2] a missing acknowledge aborts the operation; device waits to be addressed again
// [RULE3] reads go on byte after byte while the master clocks and acknowledges
// [RULE4] master withholds acknowledge after its last wanted read byte
// [RULE5] first byte after a start is the slave address
// [RULE6] upper four address bits must equal the fixed type code
// [RULE7] address bits three and two must match the chip select straps
// [RULE8] address bit one is the page bit, the ninth memory address bit
// [RULE9] address bit zero: one means read, zero means write
// [RULE10] in a write the next byte loads the low eight address bits
// [RULE11] a read uses latched low bits with the current page bit
// [RULE12] the address latch increments after each data byte, wrapping to zero
// [RULE13] no limit on bytes per operation
// [RULE14] read: send eight bits, sample acknowledge, continue or end
// [RULE15] write: take eight bits msb first, then acknowledge
// [RULE16] array written on the eighth bit; earlier start or stop leaves it
// [RULE17] no busy period after a write
// [RULE18] write protect high: no acknowledge, no write, no increment
// [RULE19] write protect low: the whole array is writable
// [RULE20] after a read address acknowledge, shift out the current byte next
// [RULE21] reads end by nack plus stop/start, or stop/start in clock nine
// [RULE22] random read: write address, word address, repeated start, read address
// [RULE23] data out on falling clock edges, captured on rising edges
// [RULE24] a stop aborts any operation and returns to idle
// [RULE25] a start at any time aborts and awaits a new slave address
// [RULE26] data line only pulled low; start and stop seen with clock high
`timescale 1ns/1ps
`include "smem_defs.svh"

module smem_target #(
   parameter logic [3:0] TYPE_CODE = `SMEM_TYPE_CODE_DEF
) (
   // system clock and reset
   input wire logic sys_clk_in,
   input wire logic arst_n_in,
   // two-wire link
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_out,
   // straps and protection
   input wire logic [1:0] chip_select_straps_in,
   input wire logic wp_in,
   // status on sys_clk_in
   output smem_pkg::smem_status_s status_out
);

   // sys_clk domain: bus condition detection
   logic scl_m_reg;
   logic scl_s_reg;
   logic scl_p_reg;
   logic sda_m_reg;
   logic sda_s_reg;
   logic sda_p_reg;
   logic idle_reg;
   logic idle_next;
   logic start_hold_reg;
   logic start_hold_next;
   logic eng_hold_reg;
   logic sel_m_reg;
   logic sel_s_reg;
   logic rd_m_reg;
   logic rd_s_reg;
   // engine levels, written on scl_in, read here only through two flops
   logic sel_lvl_reg;
   logic rd_lvl_reg;

   wire scl_high = scl_s_reg & scl_p_reg;
   wire start_seen = scl_high & sda_p_reg & ~sda_s_reg; // [RULE26]
   wire stop_seen = scl_high & ~sda_p_reg & sda_s_reg; // [RULE26]

   // stop parks the engine until the next start [RULE24]
   assign idle_next = stop_seen ? 1'b1 : (start_seen ? 1'b0 : idle_reg);
   // start holds the engine in address phase until scl falls [RULE25]
   assign start_hold_next = start_seen ? 1'b1 : (~scl_s_reg ? 1'b0 : start_hold_reg);

   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         scl_m_reg <= 1'b1;
         scl_s_reg <= 1'b1;
         scl_p_reg <= 1'b1;
         sda_m_reg <= 1'b1;
         sda_s_reg <= 1'b1;
         sda_p_reg <= 1'b1;
      end else begin
         scl_m_reg <= scl_in;
         scl_s_reg <= scl_m_reg;
         scl_p_reg <= scl_s_reg;
         sda_m_reg <= sda_in;
         sda_s_reg <= sda_m_reg;
         sda_p_reg <= sda_s_reg;
      end
   end

   // single flop drives the engine reset so it cannot glitch
   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         idle_reg <= 1'b1;
         start_hold_reg <= 1'b0;
         eng_hold_reg <= 1'b1;
      end else begin
         idle_reg <= idle_next;
         start_hold_reg <= start_hold_next;
         eng_hold_reg <= idle_next | start_hold_next;
      end
   end

   // engine state levels brought back into sys_clk
   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         sel_m_reg <= 1'b0;
         sel_s_reg <= 1'b0;
         rd_m_reg <= 1'b0;
         rd_s_reg <= 1'b0;
      end else begin
         sel_m_reg <= sel_lvl_reg;
         sel_s_reg <= sel_m_reg;
         rd_m_reg <= rd_lvl_reg;
         rd_s_reg <= rd_m_reg;
      end
   end

   assign status_out.bus_idle = idle_reg;
   assign status_out.selected = sel_s_reg;
   assign status_out.reading = rd_s_reg;

   // scl domain: protocol engine
   // engine reset released only while scl is low, so next edge is a rise
   wire eng_rst_n = arst_n_in & ~eng_hold_reg;

   smem_pkg::smem_state_e state_reg;
   smem_pkg::smem_state_e state_next;
   logic [3:0] bit_cnt_reg;
   logic [3:0] bit_cnt_next;
   logic [7:0] shift_reg;
   logic ack_pend_reg;
   logic ack_pend_next;
   smem_pkg::smem_addr_t addr_reg;
   smem_pkg::smem_addr_t addr_next;
   logic [7:0] tx_reg;
   logic oe_reg;
   logic oe_next;
   logic [1:0] cs_m_reg;
   logic [1:0] cs_s_reg;
   logic wp_m_reg;
   logic wp_s_reg;
   logic [7:0] mem [0:`SMEM_DEPTH-1];

   // straps and protect pin pass two flops on the link clock
   always_ff @(posedge scl_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         cs_m_reg <= 2'h0;
         cs_s_reg <= 2'h0;
         wp_m_reg <= 1'b0;
         wp_s_reg <= 1'b0;
      end else begin
         cs_m_reg <= chip_select_straps_in;
         cs_s_reg <= cs_m_reg;
         wp_m_reg <= wp_in;
         wp_s_reg <= wp_m_reg;
      end
   end

   // byte as it stands once the eighth bit is in, msb first [RULE15]
   wire [7:0] rx_byte = {shift_reg[6:0], sda_in};
   wire byte_done = (bit_cnt_reg == `SMEM_BIT_LAST);
   wire ack_slot = (bit_cnt_reg == `SMEM_BIT_ACK);
   wire type_ok = (rx_byte[`SMEM_SA_TYPE_HI:`SMEM_SA_TYPE_LO] == TYPE_CODE); // [RULE6]
   wire sel_ok = (rx_byte[`SMEM_SA_SEL_HI:`SMEM_SA_SEL_LO] == cs_s_reg); // [RULE7]
   wire is_read = rx_byte[`SMEM_SA_RW]; // [RULE9]
   wire wr_ok = ~wp_s_reg; // [RULE18] [RULE19]
   // one-hot state decode shared by the strobes below and the drive side
   wire st_addr = (state_reg == smem_pkg::SMEM_ST_ADDR);
   wire st_word = (state_reg == smem_pkg::SMEM_ST_WORD);
   wire st_wdata = (state_reg == smem_pkg::SMEM_ST_WDATA);
   wire st_rdata = (state_reg == smem_pkg::SMEM_ST_RDATA);
   wire wr_fire = byte_done & st_wdata & wr_ok;
   wire rd_fire = byte_done & st_rdata;
   wire addr_fire = byte_done & st_addr & type_ok & sel_ok;
   wire word_fire = byte_done & st_word;
   wire addr_wrap = (addr_reg == `SMEM_ADDR_TOP);
   wire [8:0] addr_inc = addr_wrap ? `SMEM_ADDR_RST : addr_reg + 9'h001; // [RULE12]
   // bit counter counts 0..8 forever, so any byte count works [RULE13]
   assign bit_cnt_next = ack_slot ? `SMEM_BIT_FIRST : bit_cnt_reg + 4'h1; // [RULE1]

   // address latch survives start and stop, only power-on clears it
   always_comb begin
      addr_next = addr_reg;
      if (addr_fire) begin
         addr_next = {rx_byte[`SMEM_SA_PAGE], addr_reg[7:0]}; // [RULE8] [RULE11]
      end else if (word_fire) begin
         addr_next = {addr_reg[8], rx_byte}; // [RULE10] [RULE22]
      end else if (wr_fire | rd_fire) begin
         addr_next = addr_inc; // [RULE12]
      end
   end

   always_ff @(posedge scl_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         addr_reg <= `SMEM_ADDR_RST;
      end else begin
         addr_reg <= addr_next;
      end
   end

   // array commit on the rise of the eighth data bit, before acknowledge
   // no reset on the array, so stored bytes outlive any link reset
   always_ff @(posedge scl_in) begin
      if (wr_fire) begin
         mem[addr_reg] <= rx_byte; // [RULE16] [RULE17]
      end
   end

   always_comb begin
      state_next = state_reg;
      ack_pend_next = 1'b0;
      case (state_reg)
         smem_pkg::SMEM_ST_ADDR: begin
            if (byte_done) begin
               if (type_ok & sel_ok) begin // [RULE5]
                  ack_pend_next = 1'b1;
                  state_next = is_read ? smem_pkg::SMEM_ST_RDATA : smem_pkg::SMEM_ST_WORD; // [RULE9]
               end else begin
                  state_next = smem_pkg::SMEM_ST_IGNORE;
               end
            end
         end
         smem_pkg::SMEM_ST_WORD: begin
            if (byte_done) begin
               ack_pend_next = 1'b1;
               state_next = smem_pkg::SMEM_ST_WDATA;
            end
         end
         smem_pkg::SMEM_ST_WDATA: begin
            ack_pend_next = wr_fire; // [RULE18]
         end
         smem_pkg::SMEM_ST_RDATA: begin
            // master acknowledge sampled in clock nine [RULE14] [RULE3]
            if (ack_slot & ~ack_pend_reg & sda_in) begin
               state_next = smem_pkg::SMEM_ST_IGNORE; // [RULE2] [RULE21]
            end
         end
         smem_pkg::SMEM_ST_IGNORE: begin
            state_next = smem_pkg::SMEM_ST_IGNORE;
         end
         default: begin
            state_next = smem_pkg::SMEM_ST_IGNORE;
         end
      endcase
   end

   // pending ack kept through its slot, dropped right after it [RULE1]
   wire ack_pend_upd = byte_done ? ack_pend_next : (ack_slot ? 1'b0 : ack_pend_reg);

   // capture side of the engine on rising scl [RULE23]
   always_ff @(posedge scl_in or negedge eng_rst_n) begin
      if (!eng_rst_n) begin
         state_reg <= smem_pkg::SMEM_ST_ADDR; // [RULE25]
         bit_cnt_reg <= `SMEM_BIT_FIRST;
         shift_reg <= 8'h00;
         ack_pend_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         bit_cnt_reg <= bit_cnt_next;
         shift_reg <= rx_byte;
         ack_pend_reg <= ack_pend_upd;
      end
   end

   // drive side on falling scl: ack slot or read data [RULE23]
   wire rd_phase = st_rdata & ~ack_slot;
   wire load_tx = rd_phase & (bit_cnt_reg == `SMEM_BIT_FIRST);
   wire [7:0] mem_q = mem[addr_reg];
   wire [2:0] tx_idx = 3'h7 - bit_cnt_reg[2:0];

   always_comb begin
      oe_next = 1'b0;
      if (ack_slot) begin
         oe_next = ack_pend_reg; // [RULE1] [RULE15]
      end else if (load_tx) begin
         oe_next = ~mem_q[7]; // [RULE20]
      end else if (rd_phase) begin
         oe_next = ~tx_reg[tx_idx]; // [RULE14]
      end
   end

   always_ff @(negedge scl_in or negedge eng_rst_n) begin
      if (!eng_rst_n) begin
         oe_reg <= 1'b0; // [RULE21]
         tx_reg <= 8'h00;
      end else begin
         oe_reg <= oe_next;
         if (load_tx) begin
            tx_reg <= mem_q; // [RULE11] [RULE20]
         end
      end
   end

   // levels handed to the sys_clk side through two flops
   always_ff @(posedge scl_in or negedge eng_rst_n) begin
      if (!eng_rst_n) begin
         sel_lvl_reg <= 1'b0;
         rd_lvl_reg <= 1'b0;
      end else begin
         sel_lvl_reg <= (state_next != smem_pkg::SMEM_ST_ADDR) & (state_next != smem_pkg::SMEM_ST_IGNORE);
         rd_lvl_reg <= (state_next == smem_pkg::SMEM_ST_RDATA);
      end
   end

   // open drain: only ever pull low [RULE26]
   assign sda_out = 1'b0;
   assign sda_oe_out = oe_reg;

endmodule

// ### testbench/smem_chk.sv
// Purpose: port checks on the serial memory target
// Assumes: bound to smem_target, one sys_clk_in domain
// Notes: scl_in is only sampled as data here
`timescale 1ns/1ps
module smem_chk (
   // clock and reset
   input wire logic sys_clk_in,
   input wire logic arst_n_in,
   // link and status
   input wire logic scl_in,
   input wire logic sda_out,
   input wire logic sda_oe_out,
   input wire smem_pkg::smem_status_s status_out
);
   logic [5:0] oe_run_reg;
   logic [5:0] oe_run_next;
   // address ack plus a zero byte is the longest legal pull
   assign oe_run_next = sda_oe_out ? oe_run_reg + 6'h01 : 6'h00;
   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         oe_run_reg <= 6'h00;
      end else begin
         oe_run_reg <= oe_run_next;
      end
   end
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!arst_n_in);
   a_drive_low_only:
   assert property (sda_out == 1'b0) else $error("data line driven high");
   a_pull_scl_low:
   assert property ($rose(sda_oe_out) |-> !scl_in) else $error("pull began with clock high");
   a_idle_quiet:
   assert property (status_out.bus_idle |-> !sda_oe_out) else $error("pull while bus idle");
   a_read_selected:
   assert property (status_out.reading |-> status_out.selected) else $error("read phase unselected");
   a_stop_deselect:
   assert property ($rose(status_out.bus_idle) |-> ##[0:6] !status_out.selected) else $error("stop kept select");
   a_reset_values:
   assert property ($rose(arst_n_in) |-> status_out.bus_idle && !status_out.selected && !status_out.reading)
      else $error("bad state after reset");
   a_pull_bounded:
   assert property (oe_run_reg <= 6'h1D) else $error("data line held too long");
   a_select_after_start:
   assert property ($rose(status_out.selected) |-> !status_out.bus_idle) else $error("select without start");
   c_read: cover property ($rose(status_out.reading));
   c_pull: cover property ($rose(sda_oe_out));
   c_stop: cover property ($rose(status_out.bus_idle));
endmodule

// ### testbench/smem_master.sv
// Purpose: bus master model for the two-wire link
// Assumes: pull-up on data; sda_in is the wired level
// Notes: clock stands still between frames
`timescale 1ns/1ps
module smem_master (
   // link
   input wire logic sda_in,
   output logic scl_out,
   output logic sda_pull_out
);
   initial begin
      scl_out = 1'b1;
      sda_pull_out = 1'b0;
   end
   // long phases let the start/stop detector settle
   task automatic start();
      #8 sda_pull_out = 1'b0;
      #100 scl_out = 1'b1;
      #100 sda_pull_out = 1'b1;
      #100 scl_out = 1'b0;
      #100;
   endtask
   task automatic stop();
      #8 sda_pull_out = 1'b1;
      #100 scl_out = 1'b1;
      #100 sda_pull_out = 1'b0;
      #100;
   endtask
   task automatic bit_io(input logic b, output logic r);
      #8 sda_pull_out = ~b;
      #24 scl_out = 1'b1;
      r = sda_in;
      #32 scl_out = 1'b0;
   endtask
   task automatic wr_byte(input logic [7:0] b, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(b[i], r);
      bit_io(1'b1, r);
      ack = ~r;
   endtask
   task automatic rd_byte(output logic [7:0] b, input logic more);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
      // acknowledge is a low bit: asking for more pulls the line
      bit_io(~more, r);
   endtask
endmodule

// ### testbench/tb_top.sv
// Purpose: self-checking bench for the serial memory target
// Assumes: smem_master drives the link
// Notes: expected data follows from earlier writes
`timescale 1ns/1ps
`include "smem_defs.svh"
module tb_top;
   logic sys_clk_in;
   logic arst_n_in;
   logic wp_reg;
   logic [1:0] straps_reg;
   logic ack;
   logic [7:0] d;
   wire logic scl;
   wire logic pull;
   wire logic sda_out;
   wire logic oe;
   wire logic sda = ~(oe | pull);
   smem_pkg::smem_status_s st;
   int err_total = 0;
   int n_compared = 0;
   smem_target #(.TYPE_CODE(`SMEM_TYPE_CODE_DEF)) uut (.sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in),
      .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe_out(oe),
      .chip_select_straps_in(straps_reg), .wp_in(wp_reg), .status_out(st));
   smem_master m (.sda_in(sda), .scl_out(scl), .sda_pull_out(pull));
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic end_sim();
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   function automatic logic [7:0] sa(input logic page, input logic rw);
      return {`SMEM_TYPE_CODE_DEF, 2'h2, page, rw};
   endfunction
   task automatic wr(input logic [7:0] b, input logic exp_ack);
      m.wr_byte(b, ack);
      check("ack", {7'h00, ack}, {7'h00, exp_ack});
   endtask
   task automatic rd(input logic [7:0] exp, input logic more);
      m.rd_byte(d, more);
      check("rdata", d, exp);
   endtask
   initial begin
      sys_clk_in = 1'b0;
      forever #10 sys_clk_in = ~sys_clk_in;
   end
   initial begin
      repeat (40000) @(posedge sys_clk_in);
      err_total++;
      end_sim();
   end
   initial begin
      arst_n_in = 1'b0;
      wp_reg = 1'b0;
      straps_reg = 2'h2;
      repeat (4) @(posedge sys_clk_in);
      arst_n_in <= 1'b1;
      repeat (4) @(posedge sys_clk_in);
      // sequential write over the top address
      m.start();
      wr(sa(1, 0), 1);
      wr(8'hFE, 1);
      wr(8'hA5, 1);
      wr(8'h5A, 1);
      wr(8'hC3, 1);
      m.stop();
      m.start();
      wr(sa(1, 0), 1);
      wr(8'hFE, 1);
      m.start();
      wr(sa(1, 1), 1);
      @(negedge sys_clk_in) check("status", {5'h00, st}, 8'h03);
      rd(8'hA5, 1);
      rd(8'h5A, 1);
      rd(8'hC3, 0);
      m.stop();
      // refused addresses, then a moved strap
      m.start();
      wr({`SMEM_TYPE_CODE_DEF ^ 4'h1, 2'h2, 2'h0}, 0);
      m.start();
      wr({`SMEM_TYPE_CODE_DEF, 2'h1, 2'h0}, 0);
      m.stop();
      @(posedge sys_clk_in) straps_reg <= 2'h1;
      m.start();
      wr({`SMEM_TYPE_CODE_DEF, 2'h1, 2'h0}, 1);
      m.stop();
      @(posedge sys_clk_in) straps_reg <= 2'h2;
      // protected writes leave data and latch alone
      m.start();
      wr(sa(0, 0), 1);
      @(negedge sys_clk_in) check("status", {5'h00, st}, 8'h02);
      wr(8'h10, 1);
      wr(8'h11, 1);
      m.start();
      wr(sa(0, 0), 1);
      wr(8'h10, 1);
      @(posedge sys_clk_in) wp_reg <= 1'b1;
      wr(8'h77, 0);
      wr(8'h78, 0);
      m.start();
      wr(sa(0, 1), 1);
      rd(8'h11, 0);
      m.stop();
      @(posedge sys_clk_in) wp_reg <= 1'b0;
      // partial byte cut by stop must not write
      m.start();
      wr(sa(0, 0), 1);
      wr(8'h10, 1);
      for (int i = 0; i < 4; i++) m.bit_io(1'b0, ack);
      m.stop();
      m.start();
      wr(sa(0, 0), 1);
      wr(8'h10, 1);
      m.start();
      wr(sa(0, 1), 1);
      rd(8'h11, 0);
      m.start();
      wr(sa(0, 0), 1);
      m.stop();
      repeat (10) @(negedge sys_clk_in);
      check("status", {5'h00, st}, 8'h04);
      end_sim();
   end
endmodule
bind smem_target smem_chk u_chk (.sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in), .scl_in(scl_in),
   .sda_out(sda_out), .sda_oe_out(sda_oe_out), .status_out(status_out));
